// ==== poa_former.sv ====
// Operand address former: fetch, indirect and execute phase address handling
// Contract
// [R1] Fetch copies instruction bits 0-9 into address register bits 0-9.
// [R2] Current-page fetch keeps upper address bits from the instruction's own address.
// [R3] Instruction bit 10 zero clears upper address bits; one keeps them.
// [R4] Direct field covers offsets 0000-1777 octal; higher needs page bits.
// [R5] Pages hold 2000 octal (1024) locations, equal to direct range.
// [R6] Page number is the five top address bits read as binary.
// [R7] Direct reference reaches only page zero or the current page.
// [R8] Instruction bit 15 set enters indirect phase, loading read word as address.
// [R9] After indirect, bit 15 zero goes to execute, one repeats indirect.
// [R10] At each fetch start the address register holds the instruction address.
module poa_former (
    clk_sys,
    rst_n,
    start,
    start_addr,
    mem_ack,
    mem_rdata,
    mem_req,
    mem_addr,
    exec_done,
    next_addr,
    phase,
    page_num,
    operand_addr,
    operand_valid,
    instr_word
);
    input  wire logic                         clk_sys;
    input  wire logic                         rst_n;
    input  wire logic                         start;
    input  wire logic [poa_pkg::ADDR_W-1:0]   start_addr;
    input  wire logic                         mem_ack;
    input  wire logic [poa_pkg::WORD_W-1:0]   mem_rdata;
    output wire logic                         mem_req;
    output wire logic [poa_pkg::ADDR_W-1:0]   mem_addr;
    input  wire logic                         exec_done;
    input  wire logic [poa_pkg::ADDR_W-1:0]   next_addr;
    output wire poa_pkg::poa_phase_t          phase;
    output wire logic [poa_pkg::PAGE_W-1:0]   page_num;
    output wire logic [poa_pkg::ADDR_W-1:0]   operand_addr;
    output wire logic                         operand_valid;
    output wire logic [poa_pkg::WORD_W-1:0]   instr_word;

    localparam int PW = poa_pkg::PAGE_W;
    localparam int OW = poa_pkg::OFS_W;

    typedef struct packed {
        poa_pkg::poa_phase_t        phase;
        logic                       run;
        logic [poa_pkg::ADDR_W-1:0] maddr;
        logic [poa_pkg::WORD_W-1:0] instr;
        logic                       opvalid;
    } poa_state_t;

    poa_state_t state_reg;
    poa_state_t state_next;

    poa_mem_if mif ();

    // Memory word buffer
    poa_word_buf u_buf (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .mem_ack   (mem_ack),
        .mem_rdata (mem_rdata),
        .mif       (mif)
    );

    // Read request held in fetch and indirect phases
    assign mif.req  = state_reg.run && (state_reg.phase != poa_pkg::POA_EXECUTE) && !mif.ack;
    assign mif.addr = state_reg.maddr;

    // Phase sequencing and address formation
    always_comb begin
        logic [poa_pkg::WORD_W-1:0] w;
        w          = mif.rdata;
        state_next = state_reg;
        if (start) begin
            // Load address: fetch begins at the given instruction address
            state_next.run     = 1'b1;
            state_next.phase   = poa_pkg::POA_FETCH;
            state_next.maddr   = start_addr;       // R10
            state_next.opvalid = 1'b0;
        end else if (state_reg.run) begin
            case (state_reg.phase)
                poa_pkg::POA_FETCH: begin
                    if (mif.ack) begin
                        state_next.instr = w;
                        // Offset from instruction, page bits kept or cleared
                        state_next.maddr[OW-1:0] = w[OW-1:0];   // R1 R4 R5
                        if (!w[poa_pkg::PAGE_SEL_BIT]) begin
                            state_next.maddr[poa_pkg::ADDR_W-1:OW] = poa_pkg::PAGE_ZERO; // R3 R7
                        end
                        // Otherwise upper bits stay: current page    R2 R7
                        if (w[poa_pkg::INDIRECT_BIT]) begin
                            state_next.phase = poa_pkg::POA_INDIRECT;  // R8
                        end else begin
                            state_next.phase   = poa_pkg::POA_EXECUTE;
                            state_next.opvalid = 1'b1;
                        end
                    end
                end
                poa_pkg::POA_INDIRECT: begin
                    if (mif.ack) begin
                        state_next.maddr = w[poa_pkg::ADDR_W-1:0];   // R8
                        if (!w[poa_pkg::INDIRECT_BIT]) begin
                            state_next.phase   = poa_pkg::POA_EXECUTE; // R9
                            state_next.opvalid = 1'b1;
                        end
                    end
                end
                poa_pkg::POA_EXECUTE: begin
                    if (exec_done) begin
                        // Next instruction address for the coming fetch
                        state_next.maddr   = next_addr;   // R10
                        state_next.phase   = poa_pkg::POA_FETCH;
                        state_next.opvalid = 1'b0;
                    end
                end
                default: begin
                    state_next.phase = poa_pkg::POA_FETCH;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg.phase   <= poa_pkg::POA_FETCH;
            state_reg.run     <= 1'b0;
            state_reg.maddr   <= poa_pkg::ADDR_RESET;
            state_reg.instr   <= '0;
            state_reg.opvalid <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs
    assign mem_req       = mif.req;
    assign mem_addr      = state_reg.maddr;
    assign phase         = state_reg.phase;
    assign page_num      = state_reg.maddr[poa_pkg::ADDR_W-1:OW];   // R6
    assign operand_addr  = state_reg.maddr;
    assign operand_valid = state_reg.opvalid;
    assign instr_word    = state_reg.instr;

    // Helpers for checks
    logic fetch_done;
    logic ind_done;
    assign fetch_done = state_reg.run && !start && state_reg.phase == poa_pkg::POA_FETCH && mif.ack;
    assign ind_done   = state_reg.run && !start && state_reg.phase == poa_pkg::POA_INDIRECT
                        && mif.ack;

    sequence fetch_ack_s;
        fetch_done;
    endsequence

    sequence ind_ack_s;
        ind_done;
    endsequence

    offset_copy_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R1
        fetch_ack_s |=> state_reg.maddr[OW-1:0] == $past(mif.rdata[OW-1:0]))
        else $error("offset not copied on fetch");

    current_page_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R2
        fetch_ack_s and mif.rdata[poa_pkg::PAGE_SEL_BIT]
        |=> page_num == $past(page_num))
        else $error("current page changed on fetch");

    page_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R3
        fetch_ack_s and !mif.rdata[poa_pkg::PAGE_SEL_BIT] |=> page_num == poa_pkg::PAGE_ZERO)
        else $error("page zero not selected");

    direct_reach_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R7
        fetch_ack_s |=> (page_num == poa_pkg::PAGE_ZERO || page_num == $past(page_num)))
        else $error("direct reference left allowed pages");

    page_field_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R6
        page_num == operand_addr[14:10])
        else $error("page number mismatch");

    enter_ind_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R8
        fetch_ack_s and mif.rdata[poa_pkg::INDIRECT_BIT] |=> phase == poa_pkg::POA_INDIRECT)
        else $error("indirect phase not entered");

    ind_load_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R8
        ind_ack_s |=> operand_addr == $past(mif.rdata[poa_pkg::ADDR_W-1:0]))
        else $error("indirect word not loaded");

    ind_next_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R9
        ind_ack_s |=> (phase == ($past(mif.rdata[poa_pkg::INDIRECT_BIT])
                       ? poa_pkg::POA_INDIRECT : poa_pkg::POA_EXECUTE)))
        else $error("wrong phase after indirect");

    fetch_start_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R10
        state_reg.run && !start && phase == poa_pkg::POA_EXECUTE && exec_done
        |=> phase == poa_pkg::POA_FETCH && mem_addr == $past(next_addr))
        else $error("fetch not at instruction address");

    // Waiting and holding checks: reads hold until the word arrives, execute holds until exec_done
    logic read_wait;
    assign read_wait = state_reg.run && !start && !mif.ack;

    fetch_wait_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R2
        read_wait && phase == poa_pkg::POA_FETCH
        |=> $stable(mem_addr) && phase == poa_pkg::POA_FETCH)
        else $error("address moved while fetching");

    ind_wait_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R9
        read_wait && phase == poa_pkg::POA_INDIRECT
        |=> $stable(mem_addr) && phase == poa_pkg::POA_INDIRECT)
        else $error("address moved while indirect");

    exec_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R7
        phase == poa_pkg::POA_EXECUTE && !exec_done && !start |=> $stable(operand_addr))
        else $error("operand address moved in execute");

    valid_phase_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R9
        operand_valid == (phase == poa_pkg::POA_EXECUTE))
        else $error("operand valid outside execute");

    req_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R10
        mem_req && !mem_ack |=> mem_req)
        else $error("read request dropped before answer");
endmodule

// ==== poa_pkg.sv ====
// Package of widths, field positions and phase codes for the operand address former
package poa_pkg;
    localparam int ADDR_W        = 15;                // Memory address width
    localparam int WORD_W        = 16;                // Instruction / memory word width
    localparam int OFS_W         = 10;                // Direct reference field width
    localparam int PAGE_W        = ADDR_W - OFS_W;    // Page number width
    localparam int PAGE_SEL_BIT  = 10;                // Zero/current page selector
    localparam int INDIRECT_BIT  = 15;                // Indirect flag in instruction and address word
    localparam logic [OFS_W-1:0]  OFS_MAX    = 10'h3FF;   // Last offset in a page
    localparam logic [PAGE_W-1:0] PAGE_ZERO  = 5'h00;     // Page zero number
    localparam logic [ADDR_W-1:0] ADDR_RESET = 15'h0000;  // Address register after reset

    // Machine phases
    typedef enum logic [1:0] {
        POA_FETCH,
        POA_INDIRECT,
        POA_EXECUTE
    } poa_phase_t;
endpackage

// ==== poa_mem_if.sv ====
// Interface carrying one memory read request and its returned word
interface poa_mem_if;
    logic                         req;
    logic [poa_pkg::ADDR_W-1:0]   addr;
    logic                         ack;
    logic [poa_pkg::WORD_W-1:0]   rdata;

    modport former (output req, output addr, input ack, input rdata);
    modport buffer (input req, input addr, output ack, output rdata);
endinterface

// ==== poa_word_buf.sv ====
// Registered buffer that captures a word from memory on acknowledge
module poa_word_buf (
    input  wire logic                       clk_sys,
    input  wire logic                       rst_n,
    input  wire logic                       mem_ack,
    input  wire logic [poa_pkg::WORD_W-1:0] mem_rdata,
    poa_mem_if.buffer                       mif
);
    typedef struct packed {
        logic                       ack;
        logic [poa_pkg::WORD_W-1:0] word;
    } poa_buf_state_t;

    poa_buf_state_t state_reg;
    poa_buf_state_t state_next;

    // Capture the word only while a read is outstanding
    always_comb begin
        state_next     = state_reg;
        state_next.ack = mif.req && mem_ack && !state_reg.ack;
        if (state_next.ack) begin
            state_next.word = mem_rdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign mif.ack   = state_reg.ack;
    assign mif.rdata = state_reg.word;
endmodule

// ==== poa_mem_model.sv ====
// Behavioural core memory answering read requests after a set wait
module poa_mem_model (
    clk_sys,
    rst_n,
    mem_req,
    mem_addr,
    wait_cycles,
    mem_ack,
    mem_rdata
);
    input  wire logic                       clk_sys;
    input  wire logic                       rst_n;
    input  wire logic                       mem_req;
    input  wire logic [poa_pkg::ADDR_W-1:0] mem_addr;
    input  wire logic [3:0]                 wait_cycles;
    output logic                            mem_ack;
    output logic [poa_pkg::WORD_W-1:0]      mem_rdata;

    logic [poa_pkg::WORD_W-1:0] mem [0:32767] = '{default: 16'h0000};
    logic [3:0]                 cnt_reg;

    // One-cycle ack after the wait; data line inverted after the ack and while idle, held while waiting
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mem_ack   <= 1'b0;
            mem_rdata <= 16'h0000;
            cnt_reg   <= 4'h0;
        end else begin
            mem_ack <= 1'b0;
            if (mem_ack) begin
                cnt_reg   <= 4'h0;
                mem_rdata <= ~mem_rdata; // No stale word after release
            end else if (mem_req) begin
                if (cnt_reg >= wait_cycles) begin
                    mem_ack   <= 1'b1;
                    mem_rdata <= mem[mem_addr];
                end else begin
                    cnt_reg <= cnt_reg + 4'h1;
                end
            end else begin
                mem_rdata <= ~mem_rdata;
            end
        end
    end
endmodule

// ==== testbench.sv ====
// Self-checking bench for the operand address former
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                clk_sys, rst_n, start, mem_ack, exec_done, mem_req, operand_valid;
    logic [14:0]         start_addr, mem_addr, next_addr, operand_addr;
    logic [15:0]         mem_rdata, instr_word;
    logic [4:0]          page_num;
    logic [3:0]          wait_cycles;
    poa_pkg::poa_phase_t phase;
    int                  miscompares, checked;

    poa_former poa_former_inst (.clk_sys(clk_sys), .rst_n(rst_n), .start(start),
        .start_addr(start_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .mem_req(mem_req), .mem_addr(mem_addr), .exec_done(exec_done),
        .next_addr(next_addr), .phase(phase), .page_num(page_num),
        .operand_addr(operand_addr), .operand_valid(operand_valid),
        .instr_word(instr_word));
    poa_mem_model poa_mem_model_inst (.clk_sys(clk_sys), .rst_n(rst_n), .mem_req(mem_req),
        .mem_addr(mem_addr), .wait_cycles(wait_cycles), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));

    // Clock generation
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        $display("miscompares %0d checked %0d", miscompares, checked);
        if (miscompares == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Bounded wait for a phase, sampled after the edge settles
    task automatic wait_phase(poa_pkg::poa_phase_t p);
        int n;
        n = 0;
        while (phase !== p && n < 200) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        check("phase", {14'h0000, phase}, {14'h0000, p});
    endtask

    // One instruction from start through execute, then the next fetch on to its own execute
    task automatic run(logic [14:0] pc, logic [15:0] ins, logic [14:0] op, logic [4:0] pg,
                       logic [14:0] ind);
        poa_mem_model_inst.mem[pc] = ins;
        @(posedge clk_sys);
        start      <= 1'b1;
        start_addr <= pc;
        @(posedge clk_sys);
        start <= 1'b0;
        #1;
        check("fetch req", {15'h0000, mem_req}, 16'h0001);
        check("fetch addr", {1'b0, mem_addr}, {1'b0, pc});
        if (ind != 15'h0000) begin
            wait_phase(poa_pkg::POA_INDIRECT);
            check("indirect ref", {1'b0, mem_addr}, {1'b0, ind});
        end
        wait_phase(poa_pkg::POA_EXECUTE);
        check("operand_addr", {1'b0, operand_addr}, {1'b0, op});
        check("mem_addr", {1'b0, mem_addr}, {1'b0, op});
        check("page_num", {11'h000, page_num}, {11'h000, pg});
        check("operand_valid", {15'h0000, operand_valid}, 16'h0001);
        check("instr_word", instr_word, ins);
        check("exec mem_req", {15'h0000, mem_req}, 16'h0000);
        @(posedge clk_sys);
        exec_done <= 1'b1;
        next_addr <= pc + 15'h0001;
        @(posedge clk_sys);
        exec_done <= 1'b0;
        #1;
        check("next fetch", {1'b0, mem_addr}, {1'b0, pc + 15'h0001});
        wait_phase(poa_pkg::POA_EXECUTE);
        check("next operand", {1'b0, operand_addr}, 16'h0000);
    endtask

    // Current page keeps the upper bits of the instruction address
    task automatic t_current_page();
        wait_cycles <= 4'h0;
        run(15'h05FC, 16'h6601, 15'h0601, 5'h01, 15'h0000);
    endtask

    // Selector clear forces page zero from page one
    task automatic t_page_zero();
        run(15'h05FC, 16'h6201, 15'h0201, 5'h00, 15'h0000);
    endtask

    // Last offset of the page, then one indirect step to page two
    task automatic t_indirect();
        poa_mem_model_inst.mem[15'h07FF] = 16'h0800;
        run(15'h05FD, 16'hC7FF, 15'h0800, 5'h02, 15'h07FF);
    endtask

    // Two chained indirect words with a slow memory
    task automatic t_chain_slow();
        wait_cycles <= 4'h3;
        poa_mem_model_inst.mem[15'h01FF] = 16'h8140;
        poa_mem_model_inst.mem[15'h0140] = 16'h1FFF;
        run(15'h0840, 16'h81FF, 15'h1FFF, 5'h07, 15'h01FF);
    endtask

    // Highest page, both selector values, offsets at both ends
    task automatic t_top_page();
        wait_cycles <= 4'h1;
        run(15'h7E00, 16'h0400, 15'h7C00, 5'h1F, 15'h0000);
        run(15'h7E00, 16'h03FF, 15'h03FF, 5'h00, 15'h0000);
    endtask

    // Watchdog
    initial begin
        #100000;
        miscompares++;
        results();
    end

    // Main sequence
    initial begin
        rst_n = 1'b0;
        start = 1'b0;
        exec_done = 1'b0;
        start_addr = 15'h0000;
        next_addr = 15'h0000;
        wait_cycles = 4'h0;
        repeat (20) @(posedge clk_sys);
        check("reset mem_req", {15'h0000, mem_req}, 16'h0000);
        rst_n <= 1'b1;
        t_current_page();
        t_page_zero();
        t_indirect();
        t_chain_slow();
        t_top_page();
        results();
    end
endmodule
